/* File: shared/sevrep_pkg.sv */
/*
  Constants for the status and event reporting block: register widths,
  bit positions of the operation, quality-fault and status byte registers,
  and their reset values.
  Assumes a single system clock and no register bus; every register is
  reached through dedicated strobes and data ports of the top module.
*/
// Functional notes
// - Operation and quality-fault registers are 16 bits; status byte and request enable 8.
// - A condition bit rising from zero to one sets and latches its event bit.
// - Reading an event register returns it and then clears all its bits except those set in the same cycle.
// - Each event register is masked by its own enable before summarising upward.
// - Any enabled quality-fault event sets status byte bit 3.
// - Status bits except bit 6, ANDed with enables and ORed, form bit 6.
// - The service request line is asserted while status bit 6 is one.
// - A non-empty error and event queue holds status bit 3 set.
// - A query response waiting in the output buffer sets status bit 4.
// - A command decoded without error leaves status bit 3 at zero.
// - Operation bit 1 is set while the measurement system settles.
// - Operation bit 5 follows trigger enable, held through a low external trigger.
// - Operation bit 6 is set while the transient function is armed.
// - Operation bit 14 is set while a programmed list runs.
// - Operation bit 8 marks constant voltage, bit 10 constant current regulation.
// - Bits 9 and 12 reach only the event register, never the condition view.
// - Operation bit 11 is set when a measurement sample completes.
// - Unused bits of both 16-bit registers always read zero.
// - Quality bit 0 flags current mode, bit 1 flags voltage mode.
// - Quality bit 3 flags a thermal fault, bit 6 a follower-unit fault.
// - Quality bit 12 flags voltage protection, bit 13 current protection faults.
// - With external reference enabled, any protection fault sets bits 12 and 13.
// - Quality bit 14 is set while the unit sinks energy from the load.
package sevrep_pkg;

  // Register widths
  localparam int STAT_WIDTH = 16;
  localparam int SB_WIDTH   = 8;

  // Operation register bit positions
  localparam int OP_SETTLING   = 1;
  localparam int OP_TRIG_WAIT  = 5;
  localparam int OP_TRAN_ARMED = 6;
  localparam int OP_CV         = 8;
  localparam int OP_TRAN_DONE  = 9;
  localparam int OP_CC         = 10;
  localparam int OP_SAMPLE     = 11;
  localparam int OP_LIST_DONE  = 12;
  localparam int OP_LIST_RUN   = 14;

  // Quality-fault register bit positions
  localparam int QF_CURR_MODE  = 0;
  localparam int QF_VOLT_MODE  = 1;
  localparam int QF_THERMAL    = 3;
  localparam int QF_FOLLOWER   = 6;
  localparam int QF_VOLT_PROT  = 12;
  localparam int QF_CURR_PROT  = 13;
  localparam int QF_SINKING    = 14;

  // Status byte bit positions
  localparam int SB_QUES_SUM   = 3;
  localparam int SB_MSG_AVAIL  = 4;
  localparam int SB_STD_EVENT  = 5;
  localparam int SB_REQ_SUM    = 6;
  localparam int SB_OPER_SUM   = 7;

  // Bits that may ever be one in each register; the rest read zero
  localparam logic [15:0] OP_USED_MASK   = 16'h5F62;
  localparam logic [15:0] OP_COND_MASK   = 16'h4D62;
  localparam logic [15:0] QF_USED_MASK   = 16'h704B;
  localparam logic [7:0]  SB_SRE_MASK    = 8'hBF;

  // Reset values
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [7:0]  SB_RESET   = 8'h00;

endpackage

/* File: src/sevrep_top.sv */
/*
  Status and event reporting logic of the instrument: operation and
  quality-fault condition, event and enable registers, the status byte with
  its request enable, and the service request line towards the bus host.
  Assumes every input is synchronous to CLK, that read strobes and enable
  writes are one-cycle pulses from the command handling logic, and that the
  standard event summary arrives ready-made on its own input.
*/
`timescale 1ns/10ps

module sevrep_top (
  // Clock and reset
  input  wire logic                                 CLK,
  input  wire logic                                 RESET,
  // Operation sources
  input  wire logic                                 SETTLING,
  input  wire logic                                 TRIG_ENABLED,
  input  wire logic                                 TRIG_EXTERNAL,
  input  wire logic                                 TRIG_INPUT,
  input  wire logic                                 TRANSIENT_ARMED,
  input  wire logic                                 CONST_VOLTAGE,
  input  wire logic                                 CONST_CURRENT,
  input  wire logic                                 SAMPLE_DONE,
  input  wire logic                                 TRANSIENT_DONE,
  input  wire logic                                 LIST_DONE,
  input  wire logic                                 LIST_RUNNING,
  // Quality-fault sources
  input  wire logic                                 CURRENT_MODE,
  input  wire logic                                 VOLTAGE_MODE,
  input  wire logic                                 THERMAL_FAULT,
  input  wire logic                                 FOLLOWER_FAULT,
  input  wire logic                                 VOLTAGE_PROT_FAULT,
  input  wire logic                                 CURRENT_PROT_FAULT,
  input  wire logic                                 EXT_REF_ENABLED,
  input  wire logic                                 SINKING,
  // Status byte sources
  input  wire logic                                 QUEUE_NOT_EMPTY,
  input  wire logic                                 MSG_AVAILABLE,
  input  wire logic                                 STD_EVENT_SUMMARY,
  // Register access strobes and write data
  input  wire logic                                 OPER_EVENT_READ,
  input  wire logic                                 QUES_EVENT_READ,
  input  wire logic                                 OPER_ENABLE_WRITE,
  input  wire logic                                 QUES_ENABLE_WRITE,
  input  wire logic                                 SRQ_ENABLE_WRITE,
  input  wire logic [sevrep_pkg::STAT_WIDTH-1:0]    ENABLE_DATA,
  input  wire logic [sevrep_pkg::SB_WIDTH-1:0]      SRQ_ENABLE_DATA,
  // Register contents
  output logic      [sevrep_pkg::STAT_WIDTH-1:0]    OPER_CONDITION,
  output logic      [sevrep_pkg::STAT_WIDTH-1:0]    OPER_EVENT,
  output logic      [sevrep_pkg::STAT_WIDTH-1:0]    OPER_ENABLE,
  output logic      [sevrep_pkg::STAT_WIDTH-1:0]    QUES_CONDITION,
  output logic      [sevrep_pkg::STAT_WIDTH-1:0]    QUES_EVENT,
  output logic      [sevrep_pkg::STAT_WIDTH-1:0]    FAULT_FLAG_ENABLE,
  output logic      [sevrep_pkg::SB_WIDTH-1:0]      STATUS_BYTE,
  output logic      [sevrep_pkg::SB_WIDTH-1:0]      SRQ_ENABLE,
  // Service request line to the bus host
  output logic                                      SRQ
);
  import sevrep_pkg::*;

  logic [STAT_WIDTH-1:0] next_oper_cond;
  logic [STAT_WIDTH-1:0] next_ques_cond;
  logic [STAT_WIDTH-1:0] oper_pulse;
  logic [STAT_WIDTH-1:0] oper_set;
  logic [STAT_WIDTH-1:0] ques_set;
  logic [SB_WIDTH-1:0]   next_status;
  logic                  trigger_wait_flag;
  logic                  any_prot;

  // Elaboration checks: the masks and bit positions only fit these widths
  if (STAT_WIDTH != 16) begin : g_check_stat_width
    $error("status registers must be 16 bits wide");
  end
  if (SB_WIDTH != 8) begin : g_check_sb_width
    $error("status byte must be 8 bits wide");
  end
  if (SB_SRE_MASK[SB_REQ_SUM] != 1'b0) begin : g_check_sre_mask
    $error("request summary bit must not carry an enable");
  end
  if ((OP_COND_MASK & ~OP_USED_MASK) != STAT_RESET) begin : g_check_cond_mask
    $error("condition bits must be a subset of the event bits");
  end

  // Low external trigger keeps the wait flag up until the input is high again
  always_ff @(posedge CLK) begin
    if (RESET) begin
      trigger_wait_flag <= 1'b0;
    end else if (TRIG_INPUT) begin
      trigger_wait_flag <= 1'b0;
    end else if (TRIG_EXTERNAL && TRIG_ENABLED) begin
      trigger_wait_flag <= 1'b1;
    end
  end

  // Operation condition sources; unused bits are masked to zero
  always_comb begin
    next_oper_cond = STAT_RESET;
    next_oper_cond[OP_SETTLING]   = SETTLING;
    // The latch is read one cycle late, so the bit stays a cycle past the rise
    next_oper_cond[OP_TRIG_WAIT]  = TRIG_ENABLED | trigger_wait_flag;
    next_oper_cond[OP_TRAN_ARMED] = TRANSIENT_ARMED;
    next_oper_cond[OP_CV]         = CONST_VOLTAGE;
    next_oper_cond[OP_CC]         = CONST_CURRENT;
    next_oper_cond[OP_SAMPLE]     = SAMPLE_DONE;
    next_oper_cond[OP_LIST_RUN]   = LIST_RUNNING;
    next_oper_cond = next_oper_cond & OP_COND_MASK;
  end

  // Completion pulses bypass the condition view and feed the events only
  always_comb begin
    oper_pulse = STAT_RESET;
    oper_pulse[OP_TRAN_DONE] = TRANSIENT_DONE;
    oper_pulse[OP_LIST_DONE] = LIST_DONE;
  end

  // Quality-fault condition sources
  assign any_prot = VOLTAGE_PROT_FAULT | CURRENT_PROT_FAULT;

  always_comb begin
    next_ques_cond = STAT_RESET;
    next_ques_cond[QF_CURR_MODE] = CURRENT_MODE;
    next_ques_cond[QF_VOLT_MODE] = VOLTAGE_MODE;
    next_ques_cond[QF_THERMAL]   = THERMAL_FAULT;
    next_ques_cond[QF_FOLLOWER]  = FOLLOWER_FAULT;
    // External reference cannot tell which limit tripped, so both are flagged
    next_ques_cond[QF_VOLT_PROT] = VOLTAGE_PROT_FAULT | (EXT_REF_ENABLED & any_prot);
    next_ques_cond[QF_CURR_PROT] = CURRENT_PROT_FAULT | (EXT_REF_ENABLED & any_prot);
    next_ques_cond[QF_SINKING]   = SINKING;
    next_ques_cond = next_ques_cond & QF_USED_MASK;
  end

  // Rising edges of each condition, plus completion pulses, set events
  assign oper_set = ((next_oper_cond & ~OPER_CONDITION) | oper_pulse) & OP_USED_MASK;
  assign ques_set = (next_ques_cond & ~QUES_CONDITION) & QF_USED_MASK;

  // Operation condition register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      OPER_CONDITION <= STAT_RESET;
    end else begin
      OPER_CONDITION <= next_oper_cond;
    end
  end

  // Quality-fault condition register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      QUES_CONDITION <= STAT_RESET;
    end else begin
      QUES_CONDITION <= next_ques_cond;
    end
  end

  // Per-bit event latches; a read clears, but a set in the same cycle wins so no event is lost
  for (genvar b = 0; b < STAT_WIDTH; b++) begin : g_event_bit
    // Operation event bit
    always_ff @(posedge CLK) begin
      if (RESET) begin
        OPER_EVENT[b] <= STAT_RESET[b];
      end else if (oper_set[b]) begin
        OPER_EVENT[b] <= 1'b1;
      end else if (OPER_EVENT_READ) begin
        OPER_EVENT[b] <= 1'b0;
      end
    end

    // Quality-fault event bit, same read-clear behaviour
    always_ff @(posedge CLK) begin
      if (RESET) begin
        QUES_EVENT[b] <= STAT_RESET[b];
      end else if (ques_set[b]) begin
        QUES_EVENT[b] <= 1'b1;
      end else if (QUES_EVENT_READ) begin
        QUES_EVENT[b] <= 1'b0;
      end
    end
  end

  // Operation enable; unused positions cannot be enabled
  always_ff @(posedge CLK) begin
    if (RESET) begin
      OPER_ENABLE <= STAT_RESET;
    end else if (OPER_ENABLE_WRITE) begin
      OPER_ENABLE <= ENABLE_DATA & OP_USED_MASK;
    end
  end

  // Quality-fault enable, shares the write data with the operation enable
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FAULT_FLAG_ENABLE <= STAT_RESET;
    end else if (QUES_ENABLE_WRITE) begin
      FAULT_FLAG_ENABLE <= ENABLE_DATA & QF_USED_MASK;
    end
  end

  // Request enable; bit 6 holds no enable, so the summary cannot feed itself
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SRQ_ENABLE <= SB_RESET;
    end else if (SRQ_ENABLE_WRITE) begin
      SRQ_ENABLE <= SRQ_ENABLE_DATA & SB_SRE_MASK;
    end
  end

  // Status byte bits, formed from registered events and the status byte source inputs
  always_comb begin
    next_status = SB_RESET;
    // Decoding errors reach bit 3 only through the queue, so a clean command leaves it zero
    next_status[SB_QUES_SUM]  = (|(QUES_EVENT & FAULT_FLAG_ENABLE)) | QUEUE_NOT_EMPTY;
    next_status[SB_MSG_AVAIL] = MSG_AVAILABLE;
    next_status[SB_STD_EVENT] = STD_EVENT_SUMMARY;
    next_status[SB_OPER_SUM]  = |(OPER_EVENT & OPER_ENABLE);
    next_status[SB_REQ_SUM]   = |(next_status & SRQ_ENABLE & SB_SRE_MASK);
  end

  // Status byte and request line move together from one register stage
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STATUS_BYTE <= SB_RESET;
      SRQ         <= 1'b0;
    end else begin
      STATUS_BYTE <= next_status;
      SRQ         <= next_status[SB_REQ_SUM];
    end
  end

endmodule

/* File: tb/sevrep_monitor.sv */
/* Checker: timing relations among the outputs of sevrep_top.
   Bound to sevrep_top; sees its ports only; one clock, synchronous reset. */
`timescale 1ns/10ps
module sevrep_monitor
  import sevrep_pkg::*;
(
  // Clock, reset and sources
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        TRIG_ENABLED,
  input wire logic        TRIG_EXTERNAL,
  input wire logic        TRIG_INPUT,
  input wire logic        QUEUE_NOT_EMPTY,
  input wire logic        MSG_AVAILABLE,
  input wire logic        OPER_EVENT_READ,
  // Register contents
  input wire logic [15:0] OPER_CONDITION,
  input wire logic [15:0] OPER_EVENT,
  input wire logic [15:0] OPER_ENABLE,
  input wire logic [15:0] QUES_CONDITION,
  input wire logic [15:0] QUES_EVENT,
  input wire logic [15:0] FAULT_FLAG_ENABLE,
  input wire logic [7:0]  STATUS_BYTE,
  input wire logic [7:0]  SRQ_ENABLE,
  input wire logic        SRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // External trigger pulled low while the trigger system is on
  sequence s_trig_low;
    TRIG_EXTERNAL && TRIG_ENABLED && !TRIG_INPUT;
  endsequence
  // An enabled request source, held against the enable of one cycle before
  sequence s_req_on;
    |(STATUS_BYTE & $past(SRQ_ENABLE) & SB_SRE_MASK);
  endsequence
  a_srq_line: assert property (SRQ == STATUS_BYTE[6])
    else $error("SRQ differs from status bit 6");
  a_req_sum: assert property (s_req_on |-> STATUS_BYTE[6])
    else $error("status bit 6 missing");
  a_oper_latch: assert property (!(|(OPER_CONDITION & ~$past(OPER_CONDITION) & ~OPER_EVENT)))
    else $error("operation rise not latched");
  a_ques_latch: assert property (!(|(QUES_CONDITION & ~$past(QUES_CONDITION) & ~QUES_EVENT)))
    else $error("fault rise not latched");
  a_read_clear: assert property (OPER_EVENT_READ |=>
    !(|(OPER_EVENT & ~(OPER_CONDITION & ~$past(OPER_CONDITION)) & ~16'h1200)))
    else $error("event survived a read");
  a_unused_zero: assert property (!(|(OPER_CONDITION & ~OP_COND_MASK)) &&
    !(|(QUES_CONDITION & ~QF_USED_MASK)) && !(|(OPER_EVENT & ~OP_USED_MASK)))
    else $error("unused bit set");
  a_ques_sum: assert property (1 |=> STATUS_BYTE[3] ==
    ($past(QUEUE_NOT_EMPTY) || |($past(QUES_EVENT) & $past(FAULT_FLAG_ENABLE))))
    else $error("status bit 3 wrong");
  a_oper_sum: assert property (1 |=> STATUS_BYTE[7] == |($past(OPER_EVENT) & $past(OPER_ENABLE)))
    else $error("status bit 7 wrong");
  a_msg_bit: assert property (1 |=> STATUS_BYTE[4] == $past(MSG_AVAILABLE))
    else $error("status bit 4 wrong");
  a_trig_hold: assert property (s_trig_low ##1 !TRIG_INPUT |=> OPER_CONDITION[5])
    else $error("trigger bit dropped");
  a_reset_clear: assert property (disable iff (1'b0) RESET |=>
    !(|{OPER_EVENT, QUES_EVENT, OPER_ENABLE, FAULT_FLAG_ENABLE, SRQ_ENABLE, STATUS_BYTE, SRQ}))
    else $error("state left after reset");
endmodule
bind sevrep_top sevrep_monitor mon (.CLK, .RESET, .TRIG_ENABLED, .TRIG_EXTERNAL, .TRIG_INPUT,
  .QUEUE_NOT_EMPTY, .MSG_AVAILABLE, .OPER_EVENT_READ, .OPER_CONDITION, .OPER_EVENT, .OPER_ENABLE,
  .QUES_CONDITION, .QUES_EVENT, .FAULT_FLAG_ENABLE, .STATUS_BYTE, .SRQ_ENABLE, .SRQ);

/* File: tb/sevrep_host.sv */
/* Bus host model: watches the service request line and counts requests.
   Assumes SRQ is active high and synchronous to CLK. */
`timescale 1ns/10ps
module sevrep_host (
  // Clock and request line
  input wire logic CLK,
  input wire logic SRQ,
  // Requests seen
  output int       requests
);
  logic prev = 1'b0;
  // Only new requests count; a host polls at its own pace, so a held line is one request
  always @(posedge CLK) begin
    prev <= SRQ;
    if (SRQ && !prev) requests <= requests + 1;
  end
endmodule

/* File: tb/sevrep_top_tb.sv */
/* Bench for sevrep_top: random sources, enable writes and event reads,
   each result checked against a queued note. Assumes the hand-over timing. */
`timescale 1ns/10ps
module sevrep_top_tb;
  import sevrep_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, td = 0, ld = 0, te = 0, ti = 1, rdo = 0, rdq = 0, wr = 0, look = 0;
  logic [17:0] lv = '0;
  logic [15:0] ed = '0, oc, qc, oev, qev, oe, fe;
  logic [7:0]  sd = '0, se, sb;
  logic [19:0] q [$];
  logic [19:0] e;
  wire  [15:0] outs [0:8];
  int          seed = 62, n_fail = 0, n_compared = 0, cyc = 0, requests;
  always #12.5 clk = ~clk;
  sevrep_top uut (.CLK(clk), .RESET(reset), .SETTLING(lv[0]), .TRIG_ENABLED(lv[1]), .TRIG_EXTERNAL(te),
    .TRIG_INPUT(ti), .TRANSIENT_ARMED(lv[2]), .CONST_VOLTAGE(lv[3]), .CONST_CURRENT(lv[4]),
    .SAMPLE_DONE(lv[5]), .TRANSIENT_DONE(td), .LIST_DONE(ld), .LIST_RUNNING(lv[6]), .CURRENT_MODE(lv[7]),
    .VOLTAGE_MODE(lv[8]), .THERMAL_FAULT(lv[9]), .FOLLOWER_FAULT(lv[10]), .VOLTAGE_PROT_FAULT(lv[11]),
    .CURRENT_PROT_FAULT(lv[12]), .EXT_REF_ENABLED(lv[13]), .SINKING(lv[14]), .QUEUE_NOT_EMPTY(lv[15]),
    .MSG_AVAILABLE(lv[16]), .STD_EVENT_SUMMARY(lv[17]), .OPER_EVENT_READ(rdo), .QUES_EVENT_READ(rdq),
    .OPER_ENABLE_WRITE(wr), .QUES_ENABLE_WRITE(wr), .SRQ_ENABLE_WRITE(wr), .ENABLE_DATA(ed),
    .SRQ_ENABLE_DATA(sd), .OPER_CONDITION(outs[2]), .OPER_EVENT(outs[0]), .OPER_ENABLE(outs[6]),
    .QUES_CONDITION(outs[3]), .QUES_EVENT(outs[1]), .FAULT_FLAG_ENABLE(outs[7]),
    .STATUS_BYTE(outs[4][7:0]), .SRQ_ENABLE(outs[5][7:0]), .SRQ(outs[8][0]));
  assign outs[4][15:8] = 8'h00;
  assign outs[5][15:8] = 8'h00;
  assign outs[8][15:1] = 15'h0000;
  sevrep_host host (.CLK(clk), .SRQ(outs[8][0]), .requests(requests));
  // Each look cycle settles the oldest note against the output it names
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin n_fail++; test_done(); end
    else if (look) begin
      e = q.pop_front();
      n_compared++;
      if (outs[e[19:16]] !== e[15:0]) begin
        n_fail++;
        $display("unexpected out%0d: expected %h seen %h", e[19:16], e[15:0], outs[e[19:16]]);
      end
    end
  end
  // One note per cycle; strobes stay up across back-to-back calls
  task automatic chk(input logic [3:0] s, input logic [15:0] v, input logic r);
    @(negedge clk);
    q.push_back({s, v});
    look = 1'b1;
    rdo = r && s == 0;
    rdq = r && s == 1;
  endtask
  task automatic idle;
    @(negedge clk);
    look = 0; rdo = 0; rdq = 0;
  endtask
  task automatic do_reset(input int n);
    @(negedge clk);
    reset = 1; lv = '0; te = 0; ti = 1;
    repeat (n) @(negedge clk);
    reset = 0; {oc, qc, oev, qev, oe, fe} = '0; se = '0;
    for (int i = 0; i < 9; i++) chk(4'(i), 16'h0000, 0);
    idle();
  endtask
  // New random sources and enables, with the expected register picture
  task automatic step;
    logic [15:0] no, nq;
    @(negedge clk);
    lv = 18'($random(seed)); td = 1'($random(seed)); ld = 1'($random(seed));
    ed = 16'($random(seed)); sd = 8'($random(seed)); wr = 1;
    no = '0; nq = '0;
    no[OP_SETTLING] = lv[0]; no[OP_TRIG_WAIT] = lv[1]; no[OP_TRAN_ARMED] = lv[2]; no[OP_CV] = lv[3];
    no[OP_CC] = lv[4]; no[OP_SAMPLE] = lv[5]; no[OP_LIST_RUN] = lv[6];
    nq[QF_CURR_MODE] = lv[7]; nq[QF_VOLT_MODE] = lv[8]; nq[QF_THERMAL] = lv[9]; nq[QF_FOLLOWER] = lv[10];
    nq[QF_VOLT_PROT] = lv[11] | lv[13] & lv[12]; nq[QF_CURR_PROT] = lv[12] | lv[13] & lv[11];
    nq[QF_SINKING] = lv[14];
    oev |= no & ~oc | {3'b000, ld, 2'b00, td, 9'h000};
    qev |= nq & ~qc;
    oc = no; qc = nq;
    oe = ed & OP_USED_MASK; fe = ed & QF_USED_MASK; se = sd & SB_SRE_MASK;
    sb = {|(oev & oe), 1'b0, lv[17], lv[16], lv[15] | |(qev & fe), 3'b000};
    sb[6] = |(sb & se);
    @(negedge clk);
    td = 0; ld = 0; wr = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Random rounds, then the held trigger flag, then a reset in mid-run
  initial begin
    do_reset(20);
    repeat (30) begin
      step();
      chk(2, oc, 0);
      chk(3, qc, 0);
      chk(4, {8'h00, sb}, 0);
      chk(8, {15'h0000, sb[6]}, 0);
      chk(6, oe, 0);
      chk(7, fe, 0);
      chk(5, {8'h00, se}, 0);
      chk(0, oev, 1);
      chk(0, 16'h0000, 1);
      chk(1, qev, 1);
      idle();
      oev = '0; qev = '0;
    end
    @(negedge clk);
    lv = 18'h00002; te = 1; ti = 0;
    repeat (2) @(negedge clk);
    lv = '0;
    repeat (2) @(negedge clk);
    chk(2, 16'h0020, 0);
    idle();
    ti = 1;
    repeat (3) @(negedge clk);
    chk(2, 16'h0000, 0);
    idle();
    do_reset(2);
    // Random enables make some requests certain over thirty rounds
    n_compared++;
    if (requests == 0) begin
      n_fail++;
      $display("unexpected requests: expected nonzero seen %0d", requests);
    end
    test_done();
  end
endmodule
